/* File: logic/epi_pkg.sv */
// Package for the external pin interrupt block: register offsets, fields, resets.
// Assumes a classic Wishbone slave with 32-bit data, 8-bit registers in the low byte.
package epi_pkg;

  // Register byte offsets
  localparam logic [7:0] SENSE_OFS     = 8'h00;
  localparam logic [7:0] PIN_MASK_OFS  = 8'h04;
  localparam logic [7:0] PIN_FLAG_OFS  = 8'h08;
  localparam logic [7:0] GRP_CTRL_OFS  = 8'h0c;
  localparam logic [7:0] GRP_FLAG_OFS  = 8'h10;
  localparam logic [7:0] MASK_UP_OFS   = 8'h14;
  localparam logic [7:0] MASK_LO_OFS   = 8'h18;
  localparam logic [7:0] CPU_CTRL_OFS  = 8'h1c;
  localparam logic [7:0] STATUS_OFS    = 8'h20;

  // Field positions
  localparam int SENSE_ZERO_POS = 0;
  localparam int SENSE_ONE_POS  = 2;
  localparam int GIE_POS        = 0;
  localparam int ACK0_POS       = 1;
  localparam int ACK1_POS       = 2;
  localparam int ACKG0_POS      = 3;
  localparam int ACKG1_POS      = 4;

  // Reset value and sense write mask
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] SENSE_MASK = 4'hf;

  // Sense select encodings
  localparam logic [1:0] SENSE_LOW  = 2'h0;
  localparam logic [1:0] SENSE_ANY  = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  typedef struct packed {
    logic [1:0] req_pin;
    logic [1:0] req_grp;
  } epi_req_type;

endpackage : epi_pkg

/* File: logic/epi_top.sv */
// External pin interrupt logic: two sensed pins, sixteen toggle inputs in two groups.
// Assumes a classic Wishbone master on MCLK; the I/O clock gate arrives as a level.
`timescale 1ns/1ns

module epi_top (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RSTN,
  // Wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // Pins and power state
  input  wire logic [1:0]  EXT_IRQ_PINS,
  input  wire logic [15:0] TOGGLE_INPUTS_ALL,
  input  wire logic        IO_CLK_RUN,
  // Processor side
  input  wire logic [3:0]  SERVICE_ACK,
  output logic [3:0]       IRQ_REQ,
  output logic             WAKE
);

  // Three-stage synchronisers; stage one feeds stage two only
  logic [17:0] sync1_q, sync2_q, sync3_q;
  logic [17:0] sync1_d, sync2_d, sync3_d;
  logic        io_s1_q, io_s2_q, io_s3_q;
  logic        io_s1_d, io_s2_d, io_s3_d;
  logic        io_run_q, io_run_d;

  // Registers
  logic [3:0]  sense_q, sense_d;
  logic [1:0]  pin_mask_q, pin_mask_d;
  logic [1:0]  pin_flag_q, pin_flag_d;
  logic [1:0]  grp_en_q, grp_en_d;
  logic [1:0]  grp_flag_q, grp_flag_d;
  logic [7:0]  mask_up_q, mask_up_d;
  logic [7:0]  mask_lo_q, mask_lo_d;
  logic        gie_q, gie_d;
  logic [31:0] dat_q, dat_d;
  logic        ack_q, ack_d;
  logic [3:0]  irq_q, irq_d;
  logic        wake_q, wake_d;

  epi_pkg::epi_req_type req;
  logic [1:0]  pin_now, pin_old;
  logic [15:0] tog_now, tog_old;
  logic        io_run;
  logic        wr, rd_en;
  logic [1:0]  low_lvl;
  logic [1:0]  pin_evt;
  logic [7:0]  sense_rd;

  // Two dedicated pins, each with a two-bit sense field
  localparam int N_PINS = 2;

  function automatic logic pin_event(input logic [1:0] sel, input logic now, input logic old);
    case (sel)
      epi_pkg::SENSE_ANY:  pin_event = now ^ old;
      epi_pkg::SENSE_FALL: pin_event = old & ~now;
      epi_pkg::SENSE_RISE: pin_event = ~old & now;
      default:             pin_event = 1'b0;
    endcase
  endfunction : pin_event

  function automatic logic [7:0] wr_byte(input logic [7:0] cur, input logic [3:0] sel, input logic [31:0] dat);
    wr_byte = sel[0] ? dat[7:0] : cur;
  endfunction : wr_byte

  // Sense field of one dedicated pin
  function automatic logic [1:0] sense_of(input logic [3:0] s, input int i);
    sense_of = s[2*i +: 2];
  endfunction : sense_of

  // Masked change test shared by both toggle groups
  function automatic logic grp_hit(input logic [7:0] now, input logic [7:0] old, input logic [7:0] mask);
    grp_hit = |((now ^ old) & mask);
  endfunction : grp_hit

  // Write strobe aimed at one register
  function automatic logic wr_at(input logic go, input logic [7:0] adr, input logic [7:0] ofs);
    wr_at = go & (adr == ofs);
  endfunction : wr_at

  // Pins taken whatever their direction, so self-driven levels count
  always_comb begin
    sync1_d = {EXT_IRQ_PINS, TOGGLE_INPUTS_ALL};
    sync2_d = sync1_q;
    sync3_d = sync2_q;
    io_s1_d = IO_CLK_RUN;
    io_s2_d = io_s1_q;
    io_s3_d = io_s2_q;
    // Gate level moves only once two stages agree, so a glitch never opens edge sensing
    io_run_d = (io_s2_q == io_s3_q) ? io_s3_q : io_run_q;
  end

  // A change counts while stages two and three differ
  assign pin_now = sync2_q[17:16];
  assign pin_old = sync3_q[17:16];
  assign tog_now = sync2_q[15:0];
  assign tog_old = sync3_q[15:0];
  assign io_run  = io_run_q;

  // Only cycles with ack_q low act, so a held request writes once every two cycles, never in its ack cycle
  always_comb begin
    wr    = CYC_I & STB_I & WE_I & ~ack_q;
    rd_en = CYC_I & STB_I & ~WE_I & ~ack_q;
  end

  // Dedicated pins: low level is combinational, edges need the I/O clock
  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      low_lvl[i] = (sense_of(sense_q, i) == epi_pkg::SENSE_LOW) & ~pin_now[i];
      // Edge recognition waits for the I/O clock; without it sleep holds edges off
      pin_evt[i] = io_run & pin_event(sense_of(sense_q, i), pin_now[i], pin_old[i]);
    end
  end

  // Request bundle; toggle groups never wait for the I/O clock
  always_comb begin
    req.req_pin    = low_lvl;
    req.req_grp[1] = grp_en_q[1] & grp_hit(tog_now[15:8], tog_old[15:8], mask_up_q);
    req.req_grp[0] = grp_en_q[0] & grp_hit(tog_now[7:0], tog_old[7:0], mask_lo_q);
  end

  // Control registers change only on a bus write; unused byte lanes are ignored
  always_comb begin
    sense_d    = sense_q;
    pin_mask_d = pin_mask_q;
    grp_en_d   = grp_en_q;
    mask_up_d  = mask_up_q;
    mask_lo_d  = mask_lo_q;
    gie_d      = gie_q;
    if (wr && SEL_I[0]) begin
      case (ADR_I)
        epi_pkg::SENSE_OFS:    sense_d = DAT_I[3:0] & epi_pkg::SENSE_MASK;
        epi_pkg::PIN_MASK_OFS: pin_mask_d = DAT_I[1:0];
        epi_pkg::GRP_CTRL_OFS: grp_en_d = DAT_I[1:0];
        epi_pkg::MASK_UP_OFS:  mask_up_d = wr_byte(mask_up_q, SEL_I, DAT_I);
        epi_pkg::MASK_LO_OFS:  mask_lo_d = wr_byte(mask_lo_q, SEL_I, DAT_I);
        epi_pkg::CPU_CTRL_OFS: gie_d = DAT_I[epi_pkg::GIE_POS];
        default: ;
      endcase
    end
  end

  // Flags: clears first, so a set in the same cycle wins
  always_comb begin
    pin_flag_d = pin_flag_q;
    grp_flag_d = grp_flag_q;
    if (wr_at(wr & SEL_I[0], ADR_I, epi_pkg::PIN_FLAG_OFS)) begin
      pin_flag_d = pin_flag_d & ~DAT_I[1:0];
    end
    if (wr_at(wr & SEL_I[0], ADR_I, epi_pkg::GRP_FLAG_OFS)) begin
      grp_flag_d = grp_flag_d & ~DAT_I[1:0];
    end
    pin_flag_d = pin_flag_d & ~SERVICE_ACK[1:0];
    grp_flag_d = grp_flag_d & ~SERVICE_ACK[3:2];
    pin_flag_d = pin_flag_d | pin_evt;
    grp_flag_d = grp_flag_d | req.req_grp;
    // Low-level mode keeps its flag cleared; the level itself is the request
    for (int i = 0; i < N_PINS; i++) begin
      if (sense_of(sense_q, i) == epi_pkg::SENSE_LOW) begin
        pin_flag_d[i] = 1'b0;
      end
    end
  end

  always_comb begin
    sense_rd = {4'h0, sense_q};
    dat_d = 32'h0;
    if (rd_en) begin
      case (ADR_I)
        epi_pkg::SENSE_OFS:    dat_d = {24'h0, sense_rd};
        epi_pkg::PIN_MASK_OFS: dat_d = {30'h0, pin_mask_q};
        epi_pkg::PIN_FLAG_OFS: dat_d = {30'h0, pin_flag_q};
        epi_pkg::GRP_CTRL_OFS: dat_d = {30'h0, grp_en_q};
        epi_pkg::GRP_FLAG_OFS: dat_d = {30'h0, grp_flag_q};
        epi_pkg::MASK_UP_OFS:  dat_d = {24'h0, mask_up_q};
        epi_pkg::MASK_LO_OFS:  dat_d = {24'h0, mask_lo_q};
        epi_pkg::CPU_CTRL_OFS: dat_d = {31'h0, gie_q};
        epi_pkg::STATUS_OFS:   dat_d = {26'h0, io_run, pin_now, req.req_pin, 1'b0};
        default:               dat_d = 32'h0;
      endcase
    end
    ack_d = CYC_I & STB_I & ~ack_q;
  end

  // Requests and wake
  always_comb begin
    // Level requests vanish with the level; wake skips gie_q, so a level wakes without a request only while gie_q is off
    irq_d[1:0] = {2{gie_q}} & pin_mask_q & (pin_flag_q | req.req_pin);
    irq_d[3:2] = {2{gie_q}} & grp_en_q & grp_flag_q;
    wake_d = |(pin_mask_q & req.req_pin) | |req.req_grp;
  end

  // Synchronisers reset low; every enable is off then, so first samples raise nothing
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_q  <= '0;
      sync2_q  <= '0;
      sync3_q  <= '0;
      io_s1_q  <= 1'b0;
      io_s2_q  <= 1'b0;
      io_s3_q  <= 1'b0;
      io_run_q <= 1'b0;
    end else begin
      sync1_q  <= sync1_d;
      sync2_q  <= sync2_d;
      sync3_q  <= sync3_d;
      io_s1_q  <= io_s1_d;
      io_s2_q  <= io_s2_d;
      io_s3_q  <= io_s3_d;
      io_run_q <= io_run_d;
    end
  end

  // Control registers
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      sense_q    <= '0;
      pin_mask_q <= '0;
      grp_en_q   <= '0;
      mask_up_q  <= epi_pkg::REG_RESET;
      mask_lo_q  <= epi_pkg::REG_RESET;
      gie_q      <= 1'b0;
    end else begin
      sense_q    <= sense_d;
      pin_mask_q <= pin_mask_d;
      grp_en_q   <= grp_en_d;
      mask_up_q  <= mask_up_d;
      mask_lo_q  <= mask_lo_d;
      gie_q      <= gie_d;
    end
  end

  // Flags
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_flag_q <= '0;
      grp_flag_q <= '0;
    end else begin
      pin_flag_q <= pin_flag_d;
      grp_flag_q <= grp_flag_d;
    end
  end

  // Bus answer
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      dat_q <= '0;
      ack_q <= 1'b0;
    end else begin
      dat_q <= dat_d;
      ack_q <= ack_d;
    end
  end

  // Requests and wake
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_q  <= '0;
      wake_q <= 1'b0;
    end else begin
      irq_q  <= irq_d;
      wake_q <= wake_d;
    end
  end

  assign DAT_O   = dat_q;
  assign ACK_O   = ack_q;
  assign IRQ_REQ = irq_q;
  assign WAKE    = wake_q;

endmodule : epi_top

/* File: bench/epi_sva.sv */
// Checker for epi_top: bus answers, read values, request and wake causes.
// Assumes it is bound to epi_top and sees only its ports.
`timescale 1ns/1ns
module epi_sva (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RSTN,
  // Bus
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  // Pins and requests
  input wire logic [1:0]  EXT_IRQ_PINS,
  input wire logic [15:0] TOGGLE_INPUTS_ALL,
  input wire logic [3:0]  IRQ_REQ,
  input wire logic        WAKE
);
  logic [15:0] prev_q;
  logic [3:0]  up_q;
  logic [3:0]  lo_q;
  logic [3:0]  low_q;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Cycles since each cause, saturating so stale causes never count
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      prev_q <= 16'h0000;
      up_q   <= 4'hf;
      lo_q   <= 4'hf;
      low_q  <= 4'hf;
    end else begin
      prev_q <= TOGGLE_INPUTS_ALL;
      up_q   <= (TOGGLE_INPUTS_ALL[15:8] != prev_q[15:8]) ? 4'h0 : up_q + {3'h0, up_q != 4'hf};
      lo_q   <= (TOGGLE_INPUTS_ALL[7:0] != prev_q[7:0]) ? 4'h0 : lo_q + {3'h0, lo_q != 4'hf};
      low_q  <= (EXT_IRQ_PINS != 2'h3) ? 4'h0 : low_q + {3'h0, low_q != 4'hf};
    end
  end
  a_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("no ack");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  a_unmapped_zero: assert property (ACK_O && !WE_I && ADR_I > epi_pkg::STATUS_OFS |-> DAT_O == 32'h0)
    else $error("unmapped read not zero");
  a_sense_top_zero: assert property (ACK_O && !WE_I && ADR_I == epi_pkg::SENSE_OFS |-> DAT_O[7:4] == 4'h0)
    else $error("sense top bits set");
  a_reset_quiet: assert property ($rose(RSTN) |-> IRQ_REQ == 4'h0 && !WAKE && !ACK_O)
    else $error("outputs busy after reset");
  a_upper_cause: assert property ($rose(IRQ_REQ[3]) |-> up_q < 4'h7 || $past(ACK_O && WE_I, 1))
    else $error("upper request without change");
  a_lower_cause: assert property ($rose(IRQ_REQ[2]) |-> lo_q < 4'h7 || $past(ACK_O && WE_I, 1))
    else $error("lower request without change");
  a_wake_cause: assert property ($rose(WAKE) |-> up_q < 4'h7 || lo_q < 4'h7 || low_q < 4'h7 || $past(ACK_O, 1))
    else $error("wake without cause");
  c_write: cover property (ACK_O && WE_I);
  c_upper: cover property ($rose(IRQ_REQ[3]));
  c_wake: cover property ($rose(WAKE));
endmodule : epi_sva
bind epi_top epi_sva u_sva (
  .MCLK(MCLK), .RSTN(RSTN), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
  .DAT_O(DAT_O), .ACK_O(ACK_O), .EXT_IRQ_PINS(EXT_IRQ_PINS),
  .TOGGLE_INPUTS_ALL(TOGGLE_INPUTS_ALL), .IRQ_REQ(IRQ_REQ), .WAKE(WAKE)
);

/* File: bench/epi_src.sv */
// Pin source model: drives the two sensed pins and the sixteen toggle inputs.
// Assumes the bench sets wanted levels just after the clock rises.
`timescale 1ns/1ns
module epi_src (
  // Clock
  input  wire logic        clk,
  // Wanted levels and pins
  input  wire logic [17:0] want,
  output logic      [17:0] pins
);
  initial pins = 18'h30000;
  // Every level stands a whole cycle, so no pulse is too short
  always @(posedge clk) pins <= want;
endmodule : epi_src

/* File: bench/epi_top_test.sv */
// Bench for epi_top: registers, sense modes, clock gate, random toggles.
// Assumes epi_pkg, epi_top, epi_src and epi_sva are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("wrong value %0t compare", $time); end end
module epi_top_test;
  logic        mclk, rstn, cyc, stb, we, io_run, ack, wake;
  logic [7:0]  adr, mu, ml;
  logic [31:0] dat, dat_o, q;
  logic [17:0] want, pins;
  logic [3:0]  svc, req;
  logic [15:0] r;
  int          n_fail, tests_run, m, p, i;
  epi_top dut (.MCLK(mclk), .RSTN(rstn), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(4'h1), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .EXT_IRQ_PINS(pins[17:16]),
    .TOGGLE_INPUTS_ALL(pins[15:0]), .IO_CLK_RUN(io_run), .SERVICE_ACK(svc), .IRQ_REQ(req), .WAKE(wake));
  epi_src u_src (.clk(mclk), .want(want), .pins(pins));
  function automatic logic [1:0] grp(logic [15:0] c, logic [7:0] u, logic [7:0] l);
    return {|(c[15:8] & u), |(c[7:0] & l)};
  endfunction : grp
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge mclk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  task end_of_test;
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {rstn, cyc, stb, we, adr, dat, q, svc} = '0;
    io_run = 1'b1;
    want = 18'h30000;
    n_fail = 0;
    tests_run = 0;
    i = $urandom(70);
    wt(2);
    rstn <= 1'b1;
    for (i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    wb(1'b1, 8'h28, 8'hff);
    rd(8'h28, 32'h0);
    rd(epi_pkg::STATUS_OFS, 32'h38);
    repeat (4) begin
      r = 16'($urandom);
      wb(1'b1, epi_pkg::SENSE_OFS, r[7:0]);
      rd(epi_pkg::SENSE_OFS, {28'h0, r[3:0]});
    end
    wb(1'b1, epi_pkg::CPU_CTRL_OFS, 8'h01);
    wb(1'b1, epi_pkg::PIN_MASK_OFS, 8'h03);
    for (p = 0; p < 2; p++)
      for (m = 0; m < 4; m++) begin
        wb(1'b1, epi_pkg::SENSE_OFS, 8'(m << (2 * p)));
        wb(1'b1, epi_pkg::PIN_FLAG_OFS, 8'h03);
        want[16 + p] <= 1'b0;
        wt(10);
        `CHK(req[p], m != 3)
        rd(epi_pkg::PIN_FLAG_OFS, 32'(m == 1 || m == 2) << p);
        want[16 + p] <= 1'b1;
        wt(10);
        `CHK(req[p], m != 0)
        wb(1'b1, epi_pkg::PIN_FLAG_OFS, 8'h03);
        wt(2);
        `CHK(req[p], 1'b0)
      end
    wb(1'b1, epi_pkg::SENSE_OFS, 8'h02);
    io_run <= 1'b0;
    wt(4);
    want[16] <= 1'b0;
    wt(10);
    `CHK(req[0], 1'b0)
    wb(1'b1, epi_pkg::SENSE_OFS, 8'h00);
    wt(4);
    `CHK({req[0], wake}, 2'h3)
    wb(1'b1, epi_pkg::CPU_CTRL_OFS, 8'h00);
    wt(3);
    `CHK({req[0], wake}, 2'h1)
    wb(1'b1, epi_pkg::CPU_CTRL_OFS, 8'h01);
    wb(1'b1, epi_pkg::PIN_MASK_OFS, 8'h02);
    wt(3);
    `CHK(req[0], 1'b0)
    want[16] <= 1'b1;
    io_run <= 1'b1;
    wb(1'b1, epi_pkg::GRP_CTRL_OFS, 8'h03);
    for (i = 0; i < 7; i++) begin
      mu = (i == 0) ? 8'h00 : 8'($urandom);
      ml = (i == 6) ? 8'hff : 8'($urandom);
      wb(1'b1, epi_pkg::MASK_UP_OFS, mu);
      wb(1'b1, epi_pkg::MASK_LO_OFS, ml);
      r = (i == 6) ? 16'h8001 : 16'($urandom);
      want[15:0] <= want[15:0] ^ r;
      wt(10);
      `CHK(req[3:2], grp(r, mu, ml))
      svc <= 4'hc;
      wt(1);
      svc <= 4'h0;
      wt(3);
      `CHK(req[3:2], 2'h0)
    end
    wb(1'b1, epi_pkg::GRP_CTRL_OFS, 8'h00);
    want[15:0] <= ~want[15:0];
    wt(10);
    `CHK(req[3:2], 2'h0)
    end_of_test();
  end
endmodule : epi_top_test
